// file: verilog/fdcip_pkg.sv
// Constants, types and register map of the idle and drive-polling sequencer.
// Assumes a 10 MHz system clock and a plain strobe register port.
// Function
// - Reset, software reset or wake-up always lands in the idle phase.
// - Idle shows master-request set and direction clear, awaiting an opcode.
// - First opcode byte starts command phase; command completion returns to idle.
// - Idle enters a polling phase every 1 ms at 500 kb/s.
// - The first polling phase after reset examines ready-changed status of all four drives.
// - Ready-changed toggles for all four drives only after reset, then raises one interrupt.
// - Polling-disable takes effect only if written within 500 us of reset.
// - Stepping and power-down timing run in polling even with polling disabled.
// - Polling emits a step pulse with direction for each drive with a pending step.
// - Motor off and auto power-down enabled: wait 512 ms at 500 kb/s or 1 Mb/s, then power down.
// - Four data rates; writing either rate register switches the matching filter.
// - During ID search a byte other than preamble or sync mark forces a PLL relock to reference.
// - Separated data bits are assembled into bytes for the host.
// - All logic runs from one system clock.
// - While idle the separator stays synchronized to the reference.
// - Master-request is status bit 7, data direction bit 6.
// - Power down clears master-request until wake-up has completed.
package fdcip_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_HZ = 10_000_000;
  localparam int POLL_US = 1000;
  localparam int WIN_US = 500;
  localparam int PD_MS = 512;
  localparam int WAKE_US = 2000;
  localparam int POLL_CYC = POLL_US * (CLK_HZ / 1_000_000);
  localparam int WIN_CYC = WIN_US * (CLK_HZ / 1_000_000);
  localparam int PD_CYC = PD_MS * (CLK_HZ / 1_000);
  localparam int WAKE_CYC = WAKE_US * (CLK_HZ / 1_000_000);
  // Rate weights per cycle, 500 kb/s is the base weight
  localparam logic [4:0] W_BASE = 5'd10;
  localparam logic [4:0] W_250 = 5'd5;
  localparam logic [4:0] W_300 = 5'd6;
  localparam logic [4:0] W_500 = 5'd10;
  localparam logic [4:0] W_1M = 5'd20;
  localparam logic [1:0] RATE_500 = 2'h0;
  localparam logic [1:0] RATE_300 = 2'h1;
  localparam logic [1:0] RATE_250 = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [3:0] A_MAIN_STATUS = 4'h0;
  localparam logic [3:0] A_DATA = 4'h1;
  localparam logic [3:0] A_RATE_CTL = 4'h2;
  localparam logic [3:0] A_RATE_SEL = 4'h3;
  localparam logic [3:0] A_CFG = 4'h4;
  localparam logic [3:0] A_IRQ_ST = 4'h5;
  localparam logic [3:0] A_IRQ_MSK = 4'h6;
  localparam logic [3:0] A_RDY_CHG = 4'h7;
  localparam logic [3:0] A_SENSE = 4'h8;
  localparam logic [3:0] A_STEP = 4'h9;
  localparam int MAIN_STATUS_MASTER = 7;
  localparam int MAIN_STATUS_DIR = 6;
  localparam int MAIN_STATUS_CMD = 4;
  localparam int CFG_POLL_DIS = 0;
  localparam int CFG_APD_EN = 1;
  localparam int CFG_ID_SEARCH = 2;
  localparam int CFG_SW_RESET = 7;
  localparam int EV_RDY_CHG = 0;
  localparam int EV_BYTE = 1;
  localparam int EV_STEP = 2;
  localparam int EV_PWRDN = 3;
  localparam logic [3:0] IRQ_MSK_RST = 4'h0;
  localparam logic [7:0] PREAMBLE = 8'h00;
  localparam logic [7:0] SYNC_MARK = 8'ha1;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_CMD = 5'h02,
    PH_POLL = 5'h04,
    PH_PWRDN = 5'h08,
    PH_WAKE = 5'h10
  } fdcip_phase_t;
endpackage

// file: verilog/fdcip_top.sv
// Idle, command and drive-polling phase sequencer with separator digital side.
// Assumes one system clock; motor-idle and separator pins are asynchronous.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module fdcip_top #(
  parameter int POLL_CYC = fdcip_pkg::POLL_CYC,
  parameter int WIN_CYC = fdcip_pkg::WIN_CYC,
  parameter int PD_CYC = fdcip_pkg::PD_CYC,
  parameter int WAKE_CYC = fdcip_pkg::WAKE_CYC
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  // Command engine
  input wire logic i_cmd_done,
  output logic o_cmd_phase,
  // Drive side
  input wire logic i_motor_idle,
  output logic o_step,
  output logic o_dir,
  output logic [1:0] o_step_drv,
  output logic o_power_down,
  // Data separator
  input wire logic i_sep_data,
  input wire logic i_sep_window,
  output logic [1:0] o_drate,
  output logic [3:0] o_filter_sel,
  output logic o_pll_relock,
  output logic o_sep_ref_lock
);
  import fdcip_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    fdcip_phase_t phase;
    logic [31:0] poll_acc;
    logic [31:0] pd_acc;
    logic [31:0] win_cnt;
    logic [31:0] wake_cnt;
    logic [1:0] rate;
    logic [3:0] filt;
    logic poll_dis;
    logic apd_en;
    logic id_search;
    logic [3:0] rdy_chg;
    logic rc_arm;
    logic cmd_pend;
    logic [3:0] irq_st;
    logic [3:0] irq_msk;
    logic [3:0] step_pend;
    logic [3:0] step_dir;
    logic [1:0] drv_idx;
    logic step;
    logic dir;
    logic [1:0] step_drv;
    logic [7:0] rdata;
    logic [7:0] rx_shift;
    logic [2:0] bit_cnt;
    logic [7:0] rx_byte;
    logic relock;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_f;
    logic win_prev;
  } fdcip_state_t;

  fdcip_state_t s;
  fdcip_state_t next_s;
  logic [7:0] main_status_register;
  logic [3:0] evt;
  logic [4:0] w;
  logic [4:0] w_pd;
  logic wr_cfg;
  logic sw_rst;
  logic [7:0] byte_in;
  logic [31:0] poll_tgt;
  logic [31:0] pd_tgt;

  // Targets are in base-weight units so a faster rate reaches them sooner
  assign poll_tgt = 32'(POLL_CYC) * 32'(W_BASE);
  assign pd_tgt = 32'(PD_CYC) * 32'(W_BASE);

  always_comb begin
    case (s.rate)
      RATE_250: w = W_250;
      RATE_300: w = W_300;
      RATE_1M: w = W_1M;
      default: w = W_500;
    endcase
  end
  // Power-down delay holds its figure at 1 Mb/s as at 500 kb/s
  assign w_pd = (s.rate == RATE_1M) ? W_500 : w;

  always_comb begin
    main_status_register = 8'h00;
    main_status_register[MAIN_STATUS_MASTER] = (s.phase == PH_IDLE || s.phase == PH_POLL ||
                                                s.phase == PH_CMD);
    main_status_register[MAIN_STATUS_DIR] = 1'b0;
    main_status_register[MAIN_STATUS_CMD] = (s.phase == PH_CMD);
  end
  assign wr_cfg = i_wr && (i_addr == A_CFG);
  assign sw_rst = wr_cfg && i_wdata[CFG_SW_RESET];
  assign byte_in = {s.rx_shift[6:0], s.pin_f[1]};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    evt = 4'h0;
    next_s.step = 1'b0;
    next_s.relock = 1'b0;
    // Pin synchronisers: a change counts once stages two and three agree
    next_s.pin_s1 = {i_sep_window, i_sep_data, i_motor_idle};
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_s3 = s.pin_s2;
    for (int k = 0; k < 3; k++) begin
      if (s.pin_s2[k] == s.pin_s3[k]) begin
        next_s.pin_f[k] = s.pin_s3[k];
      end
    end
    if (s.win_cnt != 32'(WIN_CYC)) begin
      next_s.win_cnt = s.win_cnt + 32'h1;
    end
    // Register writes
    if (i_wr) begin
      case (i_addr)
        A_RATE_CTL, A_RATE_SEL: begin
          next_s.rate = i_wdata[1:0];
          next_s.filt = 4'h1 << i_wdata[1:0];
        end
        A_CFG: begin
          // Late polling-disable writes are ignored
          if (s.win_cnt != 32'(WIN_CYC)) begin
            next_s.poll_dis = i_wdata[CFG_POLL_DIS];
          end
          next_s.apd_en = i_wdata[CFG_APD_EN];
          next_s.id_search = i_wdata[CFG_ID_SEARCH];
        end
        A_IRQ_MSK: next_s.irq_msk = i_wdata[3:0];
        A_SENSE: next_s.rdy_chg[i_wdata[1:0]] = 1'b0;
        A_STEP: begin
          next_s.step_pend = s.step_pend | i_wdata[3:0];
          for (int k = 0; k < 4; k++) begin
            if (i_wdata[k]) begin
              next_s.step_dir[k] = i_wdata[4 + k];
            end
          end
        end
        default: ;
      endcase
    end
    ////////////////////////////////////////////////////////////////////////
    case (s.phase)
      PH_IDLE: begin
        next_s.poll_acc = s.poll_acc + 32'(w);
        if (s.apd_en && s.pin_f[0]) begin
          next_s.pd_acc = (s.pd_acc >= pd_tgt) ? s.pd_acc : s.pd_acc + 32'(w_pd);
        end else begin
          next_s.pd_acc = 32'h0;
        end
        if (i_wr && i_addr == A_DATA) begin
          next_s.phase = PH_CMD;
        end else if (s.poll_acc + 32'(w) >= poll_tgt) begin
          next_s.phase = PH_POLL;
          next_s.poll_acc = 32'h0;
          next_s.drv_idx = 2'h0;
        end
      end
      PH_POLL: begin
        if (i_wr && i_addr == A_DATA) begin
          next_s.cmd_pend = 1'b1;
        end
        if (s.drv_idx == 2'h0 && s.rc_arm && !s.poll_dis) begin
          next_s.rdy_chg = ~s.rdy_chg;
          next_s.rc_arm = 1'b0;
          evt[EV_RDY_CHG] = 1'b1;
        end
        // One drive examined per cycle; runs regardless of polling-disable
        if (s.step_pend[s.drv_idx]) begin
          next_s.step = 1'b1;
          next_s.dir = s.step_dir[s.drv_idx];
          next_s.step_drv = s.drv_idx;
          // A same-cycle request for this drive stays pending
          next_s.step_pend[s.drv_idx] = i_wr && (i_addr == A_STEP) && i_wdata[s.drv_idx];
          evt[EV_STEP] = 1'b1;
        end
        next_s.drv_idx = s.drv_idx + 2'h1;
        if (s.drv_idx == 2'h3) begin
          next_s.cmd_pend = 1'b0;
          if (s.cmd_pend || (i_wr && i_addr == A_DATA)) begin
            next_s.phase = PH_CMD;
          end else if (s.pd_acc >= pd_tgt) begin
            next_s.phase = PH_PWRDN;
            evt[EV_PWRDN] = 1'b1;
          end else begin
            next_s.phase = PH_IDLE;
          end
        end
      end
      PH_CMD: begin
        if (i_cmd_done) begin
          next_s.phase = PH_IDLE;
          next_s.poll_acc = 32'h0;
          next_s.pd_acc = 32'h0;
        end
      end
      PH_PWRDN: begin
        if ((i_rd || i_wr) && (i_addr == A_DATA || i_addr == A_MAIN_STATUS)) begin
          next_s.phase = PH_WAKE;
          next_s.wake_cnt = 32'h0;
        end
      end
      PH_WAKE: begin
        next_s.wake_cnt = s.wake_cnt + 32'h1;
        // Master-request stays low until the clock has settled
        if (s.wake_cnt + 32'h1 >= 32'(WAKE_CYC)) begin
          next_s.phase = PH_IDLE;
          next_s.pd_acc = 32'h0;
          next_s.poll_acc = 32'h0;
        end
      end
      default: next_s.phase = PH_IDLE;
    endcase
    ////////////////////////////////////////////////////////////////////////
    // Byte assembly on each rising edge of the filtered bit window outside power down
    next_s.win_prev = s.pin_f[2];
    if (s.pin_f[2] && !s.win_prev && s.phase != PH_PWRDN) begin
      next_s.rx_shift = byte_in;
      next_s.bit_cnt = s.bit_cnt + 3'h1;
      if (s.bit_cnt == 3'h7) begin
        next_s.rx_byte = byte_in;
        evt[EV_BYTE] = 1'b1;
        if (s.id_search && byte_in != PREAMBLE && byte_in != SYNC_MARK) begin
          next_s.relock = 1'b1;
        end
      end
    end
    // Read data, one cycle after the strobe
    if (i_rd) begin
      case (i_addr)
        A_MAIN_STATUS: next_s.rdata = main_status_register;
        A_DATA: next_s.rdata = s.rx_byte;
        A_RATE_CTL, A_RATE_SEL: next_s.rdata = {6'h00, s.rate};
        A_CFG: next_s.rdata = {5'h00, s.id_search, s.apd_en, s.poll_dis};
        A_IRQ_ST: next_s.rdata = {4'h0, s.irq_st};
        A_IRQ_MSK: next_s.rdata = {4'h0, s.irq_msk};
        A_RDY_CHG: next_s.rdata = {4'h0, s.rdy_chg};
        A_STEP: next_s.rdata = {s.step_dir, s.step_pend};
        default: next_s.rdata = 8'h00;
      endcase
    end
    // Read clears status; a same-cycle event still lands
    next_s.irq_st = ((i_rd && i_addr == A_IRQ_ST) ? 4'h0 : s.irq_st) | evt;
    if (sw_rst) begin
      next_s.phase = PH_IDLE;
      next_s.rc_arm = 1'b1;
      next_s.win_cnt = 32'h0;
      next_s.poll_dis = 1'b0;
      next_s.poll_acc = 32'h0;
      next_s.pd_acc = 32'h0;
      next_s.cmd_pend = 1'b0;
      next_s.step_pend = 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
      s.phase <= PH_IDLE;
      s.rc_arm <= 1'b1;
      s.filt <= 4'h1;
      s.irq_msk <= IRQ_MSK_RST;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_rdata = s.rdata;
  assign o_irq = |(s.irq_st & s.irq_msk);
  assign o_cmd_phase = (s.phase == PH_CMD);
  assign o_step = s.step;
  assign o_dir = s.dir;
  assign o_step_drv = s.step_drv;
  assign o_power_down = (s.phase == PH_PWRDN);
  assign o_drate = s.rate;
  assign o_filter_sel = s.filt;
  assign o_pll_relock = s.relock;
  assign o_sep_ref_lock = (s.phase == PH_IDLE || s.phase == PH_POLL);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  property p_idle_flags;
    s.phase == PH_IDLE |-> main_status_register[MAIN_STATUS_MASTER] && !main_status_register[MAIN_STATUS_DIR];
  endproperty
  a_idle_flags: assert property (p_idle_flags) else $error("idle status flags wrong");

  property p_cmd_enter;
    i_ce && s.phase == PH_IDLE && i_wr && i_addr == A_DATA && !sw_rst |=> s.phase == PH_CMD;
  endproperty
  a_cmd_enter: assert property (p_cmd_enter) else $error("opcode did not start command");

  property p_cmd_exit;
    i_ce && s.phase == PH_CMD && i_cmd_done && !sw_rst
      |=> s.phase == PH_IDLE && main_status_register[MAIN_STATUS_MASTER];
  endproperty
  a_cmd_exit: assert property (p_cmd_exit) else $error("command end did not return idle");

  property p_poll_from_idle;
    s.phase == PH_POLL && $past(s.phase) != PH_POLL |-> $past(s.phase) == PH_IDLE;
  endproperty
  a_poll_from_idle: assert property (p_poll_from_idle) else $error("polling entered not from idle");

  property p_rc_irq;
    i_ce && s.phase == PH_POLL && s.drv_idx == 2'h0 && s.rc_arm && !s.poll_dis && !sw_rst
      |=> s.irq_st[EV_RDY_CHG] && s.rdy_chg == ~$past(s.rdy_chg) && !s.rc_arm;
  endproperty
  a_rc_irq: assert property (p_rc_irq) else $error("ready-changed toggle missing");

  property p_step;
    i_ce && s.phase == PH_POLL && s.step_pend[s.drv_idx]
      |=> o_step && o_dir == $past(s.step_dir[s.drv_idx]) && o_step_drv == $past(s.drv_idx);
  endproperty
  a_step: assert property (p_step) else $error("step pulse or direction wrong");

  property p_late_cfg;
    i_ce && wr_cfg && !sw_rst && s.win_cnt == 32'(WIN_CYC) |=> s.poll_dis == $past(s.poll_dis);
  endproperty
  a_late_cfg: assert property (p_late_cfg) else $error("late polling disable accepted");

  property p_pd_delay;
    s.phase == PH_PWRDN && $past(s.phase) == PH_POLL |-> $past(s.pd_acc) >= pd_tgt;
  endproperty
  a_pd_delay: assert property (p_pd_delay) else $error("power down before delay");

  property p_filter;
    o_filter_sel == (4'h1 << o_drate);
  endproperty
  a_filter: assert property (p_filter) else $error("filter does not match rate");

  property p_pd_master;
    s.phase == PH_PWRDN || s.phase == PH_WAKE |-> !main_status_register[MAIN_STATUS_MASTER];
  endproperty
  a_pd_master: assert property (p_pd_master) else $error("master request set in power down");

  property p_step_keep;
    i_ce && i_wr && i_addr == A_STEP |=> (s.step_pend & $past(i_wdata[3:0])) == $past(i_wdata[3:0]);
  endproperty
  a_step_keep: assert property (p_step_keep) else $error("step request lost");

  property p_irq_sticky;
    i_ce && !(i_rd && i_addr == A_IRQ_ST) |=> (s.irq_st & $past(s.irq_st)) == $past(s.irq_st);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("status bit cleared without read");

  property p_relock_search;
    o_pll_relock |-> $past(s.id_search);
  endproperty
  a_relock_search: assert property (p_relock_search) else $error("relock outside ID search");

  property p_ce_freeze;
    !i_ce |=> s == $past(s);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

  c_poll: cover property (s.phase == PH_IDLE ##1 s.phase == PH_POLL);
  c_pwrdn: cover property (s.phase == PH_POLL ##1 s.phase == PH_PWRDN);
  c_byte: cover property (s.irq_st[EV_BYTE]);
  c_relock: cover property (o_pll_relock);
  c_wake: cover property (s.phase == PH_WAKE ##1 s.phase == PH_IDLE);
endmodule

// file: bench/fdcip_drive_model.sv
// Drive-side stand-in: motor-idle pin, separated data, bit window, head positions.
// Assumes the bench calls its tasks from one process, right after a rising edge.
`timescale 1ns/1ns
module fdcip_drive_model (
  // Clock
  input wire logic i_clk_sys,
  // Step pins from the block
  input wire logic i_step,
  input wire logic i_dir,
  input wire logic [1:0] i_step_drv,
  // Pins to the block
  output logic o_motor_idle,
  output logic o_sep_data,
  output logic o_sep_window
);
  int head [4];
  initial begin
    o_motor_idle = 1'b0;
    o_sep_data = 1'b0;
    o_sep_window = 1'b0;
    foreach (head[k]) head[k] = 0;
  end
  ////////////////////////////////////////////////////////////
  // Head moves one track per step pulse, toward the direction level
  always @(posedge i_clk_sys) begin
    if (i_step === 1'b1) begin
      head[i_step_drv] <= (i_dir === 1'b1) ? head[i_step_drv] + 1 : head[i_step_drv] - 1;
    end
  end
  task automatic set_motor_idle(input logic v);
    @(posedge i_clk_sys);
    o_motor_idle <= v;
  endtask
  // Six cycles a level, safely above the block's input filter
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk_sys);
      o_sep_data <= b[i];
      repeat (6) @(posedge i_clk_sys);
      o_sep_window <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      o_sep_window <= 1'b0;
      // No bit outside the window, so never leave the old one standing
      o_sep_data <= ~b[i];
    end
  endtask
endmodule

// file: bench/fdcip_top_tb.sv
// Self-checking bench of the idle, command and drive-polling sequencer.
// Assumes the drive model owns the drive pins and the bench owns the register port.
`timescale 1ns/1ns
module fdcip_top_tb;
  import fdcip_pkg::*;
  localparam int P_POLL = 40;
  localparam int P_WIN = 60;
  localparam int P_PD = 100;
  localparam int P_WAKE = 10;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cmd_done = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq, o_cmd_phase, o_step, o_dir, o_power_down, o_pll_relock, o_sep_ref_lock;
  logic [1:0] o_step_drv, o_drate;
  logic [3:0] o_filter_sel;
  logic motor_idle, sep_data, sep_window;
  logic [15:0] exp_q [$];
  logic rd_seen = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  int n_relock = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  ////////////////////////////////////////////////////////////
  fdcip_top #(.POLL_CYC(P_POLL), .WIN_CYC(P_WIN), .PD_CYC(P_PD), .WAKE_CYC(P_WAKE)) u_fdcip_top (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_cmd_done(i_cmd_done),
    .o_cmd_phase(o_cmd_phase), .i_motor_idle(motor_idle), .o_step(o_step), .o_dir(o_dir),
    .o_step_drv(o_step_drv), .o_power_down(o_power_down), .i_sep_data(sep_data),
    .i_sep_window(sep_window), .o_drate(o_drate), .o_filter_sel(o_filter_sel),
    .o_pll_relock(o_pll_relock), .o_sep_ref_lock(o_sep_ref_lock));
  fdcip_drive_model u_fdcip_drive_model (
    .i_clk_sys(i_clk_sys), .i_step(o_step), .i_dir(o_dir), .i_step_drv(o_step_drv),
    .o_motor_idle(motor_idle), .o_sep_data(sep_data), .o_sep_window(sep_window));
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Read answers appear in the cycle after the strobe and hold until the next read
  always @(posedge i_clk_sys) begin
    logic [15:0] e;
    if (rd_seen) begin
      e = exp_q.pop_front();
      chk(o_rdata & e[15:8], e[7:0]);
    end
    rd_seen <= i_rd;
    if (o_pll_relock === 1'b1) n_relock <= n_relock + 1;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back({m, e});
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic sense_all();
    for (int d = 0; d < 4; d++) wr(A_SENSE, 8'(d));
  endtask
  // Bounded wait: 0 command, 1 step, 2 power down, 3 awake
  task automatic wait_until(input int which, input int lim, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      cyc(1);
      n++;
      case (which)
        0: hit = (o_cmd_phase === 1'b1);
        1: hit = (o_step === 1'b1);
        2: hit = (o_power_down === 1'b1);
        default: hit = (o_power_down === 1'b0);
      endcase
      if (!hit && n >= lim) begin
        n_mismatch++;
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 0, which + 1);
        report_and_stop();
      end
    end
  endtask
  initial begin
    int n;
    int r0;
    int iv;
    logic [7:0] bytes [4];
    void'($urandom(32'h7fc0));
    cyc(10);
    chk(o_filter_sel, 4'h1);
    chk(o_drate, 2'h0);
    chk(o_sep_ref_lock, 1'b1);
    @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rd(A_MAIN_STATUS, 8'hd0, 8'h80);
    rd(4'hf, 8'hff, 8'h00);
    wr(A_IRQ_MSK, 8'h01);
    $display("test idle done");
    cyc(P_POLL + 10);
    chk(o_irq, 1'b1);
    rd(A_RDY_CHG, 8'h0f, 8'h0f);
    rd(A_IRQ_ST, 8'h01, 8'h01);
    cyc(2);
    chk(o_irq, 1'b0);
    sense_all();
    rd(A_RDY_CHG, 8'h0f, 8'h00);
    $display("test ready_changed done");
    wr(A_DATA, 8'h0a);
    wait_until(0, 12, n);
    chk(o_sep_ref_lock, 1'b0);
    rd(A_MAIN_STATUS, 8'hd0, 8'h90);
    @(posedge i_clk_sys);
    i_cmd_done <= 1'b1;
    @(posedge i_clk_sys);
    i_cmd_done <= 1'b0;
    cyc(2);
    chk(o_cmd_phase, 1'b0);
    chk(o_sep_ref_lock, 1'b1);
    $display("test command done");
    // Each rate: filter, read-back, step on drive c, then one poll period
    for (int c = 0; c < 4; c++) begin
      wr(c[0] ? A_RATE_SEL : A_RATE_CTL, 8'(c));
      cyc(1);
      chk(o_drate, c[1:0]);
      chk(o_filter_sel, 4'h1 << c);
      rd(c[0] ? A_RATE_SEL : A_RATE_CTL, 8'h03, 8'(c));
      wr(A_STEP, 8'(((c % 2) << (c + 4)) | (1 << c)));
      wait_until(1, 200, n);
      chk(o_step_drv, c[1:0]);
      chk(o_dir, c[0]);
      wr(A_STEP, 8'(((c % 2) << (c + 4)) | (1 << c)));
      wait_until(1, 200, n);
      iv = c == 0 ? W_500 : c == 1 ? W_300 : c == 2 ? W_250 : W_1M;
      iv = (P_POLL * W_BASE + iv - 1) / iv;
      chk(n >= iv - 5 && n <= iv + 5, 1'b1);
    end
    wr(A_RATE_CTL, 8'h00);
    chk(u_fdcip_drive_model.head[1], 2);
    $display("test rates_steps done");
    wr(A_CFG, 8'h80);
    wr(A_CFG, 8'h01);
    cyc(2 * P_POLL);
    rd(A_RDY_CHG, 8'h0f, 8'h00);
    rd(A_MAIN_STATUS, 8'hd0, 8'h80);
    wr(A_STEP, 8'h44);
    wait_until(1, 3 * P_POLL, n);
    chk(o_step_drv, 2'h2);
    chk(o_dir, 1'b1);
    wr(A_CFG, 8'h80);
    cyc(P_POLL + 10);
    rd(A_RDY_CHG, 8'h0f, 8'h0f);
    sense_all();
    $display("test soft_reset done");
    // Late polling-disable attempt rides along with the ID search enable
    cyc(P_WIN);
    wr(A_CFG, 8'h05);
    rd(A_CFG, 8'h07, 8'h04);
    bytes = '{8'h00, SYNC_MARK, PREAMBLE, 8'h00};
    bytes[0] = 8'($urandom);
    bytes[3] = 8'($urandom);
    for (int k = 0; k < 4; k++) begin
      r0 = n_relock;
      u_fdcip_drive_model.send_byte(bytes[k]);
      cyc(12);
      chk(n_relock - r0, (bytes[k] == PREAMBLE || bytes[k] == SYNC_MARK) ? 0 : 1);
      rd(A_DATA, 8'hff, bytes[k]);
    end
    $display("test separator done");
    // Enable low: a pending step must wait for the enable to return
    wr(A_STEP, 8'h08);
    i_ce <= 1'b0;
    cyc(3 * P_POLL);
    chk(o_step_drv, 2'h2);
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    wait_until(1, 2 * P_POLL, n);
    chk(o_step_drv, 2'h3);
    chk(o_dir, 1'b0);
    $display("test clock_enable done");
    wr(A_CFG, 8'h02);
    u_fdcip_drive_model.set_motor_idle(1'b1);
    wait_until(2, P_PD + 6 * P_POLL, n);
    chk(n > P_PD, 1'b1);
    rd(A_IRQ_ST, 8'h08, 8'h08);
    u_fdcip_drive_model.set_motor_idle(1'b0);
    rd(A_MAIN_STATUS, 8'hd0, 8'h00);
    wait_until(3, 4, n);
    rd(A_MAIN_STATUS, 8'h80, 8'h00);
    cyc(P_WAKE + 4);
    rd(A_MAIN_STATUS, 8'hd0, 8'h80);
    cyc(2);
    $display("test power_down done");
    report_and_stop();
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge i_clk_sys);
    n_mismatch++;
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 1, 0);
    report_and_stop();
  end
endmodule
